// ==== src/dsos_pkg.sv ====
// Package for the drive status output selector.
// Assumes a 20 MHz system clock and the plain register port of the top module.
package dsos_pkg;

  // ---------------------------------------------------------------
  // Bus and selector widths
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned SEL_W    = 6;
  localparam int unsigned NUM_SRC  = 64;
  localparam int unsigned NUM_TERM = 4;

  // ---------------------------------------------------------------
  // Terminal indices
  // ---------------------------------------------------------------
  localparam int unsigned TERM_RELAY_1 = 0;
  localparam int unsigned TERM_RELAY_2 = 1;
  localparam int unsigned TERM_OC      = 2;
  localparam int unsigned TERM_FAST    = 3;

  // ---------------------------------------------------------------
  // Register word addresses
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_SEL_RELAY_1 = 4'h0;
  localparam logic [3:0] ADDR_SEL_RELAY_2 = 4'h1;
  localparam logic [3:0] ADDR_SEL_OC      = 4'h2;
  localparam logic [3:0] ADDR_SEL_FAST    = 4'h3;
  localparam logic [3:0] ADDR_FAST_TYPE   = 4'h4;
  localparam logic [3:0] ADDR_TERM_STATE  = 4'h5;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [5:0] RST_SEL_RELAY_1 = 6'h01;
  localparam logic [5:0] RST_SEL_RELAY_2 = 6'h05;
  localparam logic [5:0] RST_SEL_OC      = 6'h00;
  localparam logic [5:0] RST_SEL_FAST    = 6'h00;
  localparam logic       RST_FAST_TYPE   = 1'b0;
  localparam logic       FAST_TYPE_PULSE = 1'b0;

  // ---------------------------------------------------------------
  // Function codes
  // ---------------------------------------------------------------
  localparam logic [5:0] FC_NONE       = 6'h00;
  localparam logic [5:0] FC_RUN        = 6'h01;
  localparam logic [5:0] FC_RUN_FWD    = 6'h02;
  localparam logic [5:0] FC_RUN_REV    = 6'h03;
  localparam logic [5:0] FC_JOG        = 6'h04;
  localparam logic [5:0] FC_FAULT      = 6'h05;
  localparam logic [5:0] FC_LEVEL_1    = 6'h06;
  localparam logic [5:0] FC_LEVEL_2    = 6'h07;
  localparam logic [5:0] FC_FREQ_REACH = 6'h08;
  localparam logic [5:0] FC_ZERO_SPEED = 6'h09;
  localparam logic [5:0] FC_UPPER_LIM  = 6'h0A;
  localparam logic [5:0] FC_LOWER_LIM  = 6'h0B;
  localparam logic [5:0] FC_READY      = 6'h0C;
  localparam logic [5:0] FC_PRE_EXCITE = 6'h0D;
  localparam logic [5:0] FC_OVERLOAD   = 6'h0E;
  localparam logic [5:0] FC_UNDERLOAD  = 6'h0F;
  localparam logic [5:0] FC_SEQ_STAGE  = 6'h10;
  localparam logic [5:0] FC_SEQ_CYCLE  = 6'h11;
  localparam logic [5:0] FC_VT_SERIAL  = 6'h17;
  localparam logic [5:0] FC_VT_FIELD   = 6'h18;
  localparam logic [5:0] FC_VT_ETH     = 6'h19;
  localparam logic [5:0] FC_DC_BUS_OK  = 6'h1A;
  localparam logic [5:0] FC_INDEX      = 6'h1B;
  localparam logic [5:0] FC_SUPERPOSE  = 6'h1C;
  localparam logic [5:0] FC_STO_FAULT  = 6'h1D;
  localparam logic [5:0] FC_POS_DONE   = 6'h1E;
  localparam logic [5:0] FC_ZERO_DONE  = 6'h1F;
  localparam logic [5:0] FC_DIV_DONE   = 6'h20;
  localparam logic [5:0] FC_TRQ_LIMIT  = 6'h21;
  localparam logic [5:0] FC_VT_IND_ETH = 6'h22;
  localparam logic [5:0] FC_MODE_DONE  = 6'h24;
  localparam logic [5:0] FC_ANY_FREQ   = 6'h25;
  localparam logic [5:0] FC_CARD_OC_1  = 6'h29;
  localparam logic [5:0] FC_CARD_OC_2  = 6'h2A;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned INDEX_HOLD_MS = 10;
  localparam int unsigned INDEX_HOLD_CYC = INDEX_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned INDEX_CNT_W   = 18;

endpackage : dsos_pkg

// ==== src/dsos_selector.sv ====
// Output terminal selector: routes drive status conditions to four terminals.
// Assumes all condition inputs are synchronous to sys_clk and held by the drive core.
//
// Functional notes
// - Two relays, one open-collector, one fast terminal; fast one pulse or digital.
// - Same code may be chosen on several terminals, all driven alike except virtual-bit codes and the fast one in pulse mode.
// - Code 0 gives the terminal no function; it stays off, except the fast one in pulse mode, which follows the pulse train.
// - Codes 1-4: on with output frequency while running, forward, reverse, jogging.
// - Code 5: on while the drive is faulted.
// - Codes 6,7 pass frequency level flags; code 8 frequency reached.
// - Code 9: on only when output and reference frequency are both zero.
// - Codes 10,11: on at upper and at lower frequency limit.
// - Code 12: on when powers established, no protection active, ready to run.
// - Code 13: on while the motor is being pre-excited.
// - Codes 14,15: overload and underload pre-alarm after pre-alarm time.
// - Codes 16,17: sequencer stage done and full cycle done.
// - Codes 23-25 follow serial, fieldbus and Ethernet virtual bits.
// - Code 34 follows the industrial-Ethernet virtual bit.
// - Code 26: on while DC bus is above undervoltage threshold.
// - Code 27: index pulse stretched to 10 ms.
// - Code 28: on while pulse superposition is active.
// - Code 29: on when a safe torque off fault occurred.
// - Codes 30,31,32,36: positioning, zeroing, scale division, mode switch done.
// - Code 33: on while frequency is limited in torque control.
// - Code 37: on when ramp reference exceeds the reach detection value.
// - Codes 41,42 follow the card open-collector outputs.
// - Fast terminal type 0 gives pulse output, 1 digital; reset 0.
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns

module dsos_selector #(
  parameter int unsigned INDEX_HOLD_CYCLES = dsos_pkg::INDEX_HOLD_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Drive core status
  input  wire logic       run_active,
  input  wire logic       run_reverse,
  input  wire logic       jog_active,
  input  wire logic       freq_output_nonzero,
  input  wire logic       drive_fault,
  input  wire logic       freq_level_flag_1,
  input  wire logic       freq_level_flag_2,
  input  wire logic       freq_reached,
  input  wire logic       out_freq_zero,
  input  wire logic       ref_freq_zero,
  input  wire logic       at_upper_limit,
  input  wire logic       at_lower_limit,
  input  wire logic       power_established,
  input  wire logic       protection_active,
  input  wire logic       ready_to_run,
  input  wire logic       pre_exciting,
  input  wire logic       overload_prealarm,
  input  wire logic       underload_prealarm,
  input  wire logic       simple_sequencer_stage_done,
  input  wire logic       simple_sequencer_cycle_done,
  input  wire logic       dc_bus_above_uv,
  input  wire logic       encoder_index_pulse,
  input  wire logic       pulse_superpose_active,
  input  wire logic       safe_torque_off_fault,
  input  wire logic       positioning_done,
  input  wire logic       spindle_zero_done,
  input  wire logic       spindle_div_done,
  input  wire logic       torque_freq_limited,
  input  wire logic       mode_switch_done,
  input  wire logic       ramp_ref_above_reach,
  input  wire logic       card_open_collector_out_1,
  input  wire logic       card_open_collector_out_2,
  input  wire logic       fast_pulse_train,
  // Virtual terminal bits, one per terminal
  input  wire logic [3:0] vt_serial_bits,
  input  wire logic [3:0] vt_fieldbus_bits,
  input  wire logic [3:0] vt_ethernet_bits,
  input  wire logic [3:0] vt_ind_eth_bits,
  // Terminals
  output logic            relay_out_1,
  output logic            relay_out_2,
  output logic            oc_out,
  output logic            fast_pulse_out
);

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [5:0] sel_q [4];
  logic       fast_type_q;
  logic [3:0] term_q;
  logic [3:0] term_addr [4];

  assign term_addr[0] = dsos_pkg::ADDR_SEL_RELAY_1;
  assign term_addr[1] = dsos_pkg::ADDR_SEL_RELAY_2;
  assign term_addr[2] = dsos_pkg::ADDR_SEL_OC;
  assign term_addr[3] = dsos_pkg::ADDR_SEL_FAST;

  // Fast terminal type, pulse mode after reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fast_type_q <= dsos_pkg::RST_FAST_TYPE;
    end else if (reg_wr && reg_addr == dsos_pkg::ADDR_FAST_TYPE) begin
      fast_type_q <= reg_wdata[0];
    end
  end

  // ---------------------------------------------------------------
  // Index pulse stretcher
  // ---------------------------------------------------------------
  logic [17:0] index_cnt_q;
  logic        index_active;

  // Retriggers on every index pulse, so a fast encoder keeps it high
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      index_cnt_q <= 18'h0_0000;
    end else if (encoder_index_pulse) begin
      index_cnt_q <= INDEX_HOLD_CYCLES[17:0];
    end else if (index_cnt_q != 18'h0_0000) begin
      index_cnt_q <= index_cnt_q - 18'h0_0001;
    end
  end

  assign index_active = (index_cnt_q != 18'h0_0000);

  // ---------------------------------------------------------------
  // Common condition vector, indexed by function code
  // ---------------------------------------------------------------
  logic [63:0] cond;
  logic        producing;

  assign producing = run_active & freq_output_nonzero;

  // Unlisted codes stay zero so that reserved selections read as off
  always_comb begin
    cond                            = 64'h0000_0000_0000_0000;
    cond[dsos_pkg::FC_NONE]         = 1'b0;
    cond[dsos_pkg::FC_RUN]          = producing;
    cond[dsos_pkg::FC_RUN_FWD]      = producing & ~run_reverse;
    cond[dsos_pkg::FC_RUN_REV]      = producing & run_reverse;
    cond[dsos_pkg::FC_JOG]          = jog_active & freq_output_nonzero;
    cond[dsos_pkg::FC_FAULT]        = drive_fault;
    cond[dsos_pkg::FC_LEVEL_1]      = freq_level_flag_1;
    cond[dsos_pkg::FC_LEVEL_2]      = freq_level_flag_2;
    cond[dsos_pkg::FC_FREQ_REACH]   = freq_reached;
    cond[dsos_pkg::FC_ZERO_SPEED]   = out_freq_zero & ref_freq_zero;
    cond[dsos_pkg::FC_UPPER_LIM]    = at_upper_limit;
    cond[dsos_pkg::FC_LOWER_LIM]    = at_lower_limit;
    cond[dsos_pkg::FC_READY]        = power_established & ~protection_active
                                      & ready_to_run;
    cond[dsos_pkg::FC_PRE_EXCITE]   = pre_exciting;
    cond[dsos_pkg::FC_OVERLOAD]     = overload_prealarm;
    cond[dsos_pkg::FC_UNDERLOAD]    = underload_prealarm;
    cond[dsos_pkg::FC_SEQ_STAGE]    = simple_sequencer_stage_done;
    cond[dsos_pkg::FC_SEQ_CYCLE]    = simple_sequencer_cycle_done;
    cond[dsos_pkg::FC_DC_BUS_OK]    = dc_bus_above_uv;
    cond[dsos_pkg::FC_INDEX]        = index_active;
    cond[dsos_pkg::FC_SUPERPOSE]    = pulse_superpose_active;
    cond[dsos_pkg::FC_STO_FAULT]    = safe_torque_off_fault;
    cond[dsos_pkg::FC_POS_DONE]     = positioning_done;
    cond[dsos_pkg::FC_ZERO_DONE]    = spindle_zero_done;
    cond[dsos_pkg::FC_DIV_DONE]     = spindle_div_done;
    cond[dsos_pkg::FC_MODE_DONE]    = mode_switch_done;
    cond[dsos_pkg::FC_TRQ_LIMIT]    = torque_freq_limited;
    cond[dsos_pkg::FC_ANY_FREQ]     = ramp_ref_above_reach;
    cond[dsos_pkg::FC_CARD_OC_1]    = card_open_collector_out_1;
    cond[dsos_pkg::FC_CARD_OC_2]    = card_open_collector_out_2;
  end

  // ---------------------------------------------------------------
  // Per-terminal selection
  // ---------------------------------------------------------------
  for (genvar t = 0; t < 4; t++) begin : g_term
    logic [63:0] src;

    // Virtual bits are per terminal, so the common vector is patched here
    always_comb begin
      src                         = cond;
      src[dsos_pkg::FC_VT_SERIAL]  = vt_serial_bits[t];
      src[dsos_pkg::FC_VT_FIELD]   = vt_fieldbus_bits[t];
      src[dsos_pkg::FC_VT_ETH]     = vt_ethernet_bits[t];
      src[dsos_pkg::FC_VT_IND_ETH] = vt_ind_eth_bits[t];
    end

    // Function code per terminal
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        case (t)
          0:       sel_q[t] <= dsos_pkg::RST_SEL_RELAY_1;
          1:       sel_q[t] <= dsos_pkg::RST_SEL_RELAY_2;
          2:       sel_q[t] <= dsos_pkg::RST_SEL_OC;
          default: sel_q[t] <= dsos_pkg::RST_SEL_FAST;
        endcase
      end else if (reg_wr && reg_addr == term_addr[t]) begin
        sel_q[t] <= reg_wdata[5:0];
      end
    end

    // Each terminal looks up its own code; equal codes give equal outputs unless they select per-terminal virtual bits
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        term_q[t] <= 1'b0;
      end else begin
        term_q[t] <= src[sel_q[t]];
      end
    end

    property p_code_zero_off;
      @(posedge sys_clk) disable iff (rst)
        (sel_q[t] == dsos_pkg::FC_NONE) |=> !term_q[t];
    endproperty
    a_code_zero_off: assert property (p_code_zero_off)
      else $error("terminal active with code zero");

    property p_follow_source;
      @(posedge sys_clk) disable iff (rst)
        (sel_q[t] == dsos_pkg::FC_VT_SERIAL) |=> term_q[t] == $past(vt_serial_bits[t]);
    endproperty
    a_follow_source: assert property (p_follow_source)
      else $error("terminal did not follow its selected source");

    property p_reserved_off;
      @(posedge sys_clk) disable iff (rst)
        (sel_q[t] inside {[6'h12:6'h16], 6'h23, [6'h26:6'h28]} || sel_q[t] >= 6'h2B)
          |=> !term_q[t];
    endproperty
    a_reserved_off: assert property (p_reserved_off)
      else $error("reserved code drove a terminal");
  end

  // ---------------------------------------------------------------
  // Terminal pins
  // ---------------------------------------------------------------
  logic fast_q;

  // Pulse mode passes the core's pulse train; digital mode uses the selection
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fast_q <= 1'b0;
    end else if (fast_type_q == dsos_pkg::FAST_TYPE_PULSE) begin
      fast_q <= fast_pulse_train;
    end else begin
      fast_q <= src_fast();
    end
  end

  function automatic logic src_fast();
    return g_term[3].src[sel_q[3]];
  endfunction : src_fast

  assign relay_out_1    = term_q[dsos_pkg::TERM_RELAY_1];
  assign relay_out_2    = term_q[dsos_pkg::TERM_RELAY_2];
  assign oc_out         = term_q[dsos_pkg::TERM_OC];
  assign fast_pulse_out = fast_q;

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  // Data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        dsos_pkg::ADDR_SEL_RELAY_1: reg_rdata <= {2'b00, sel_q[0]};
        dsos_pkg::ADDR_SEL_RELAY_2: reg_rdata <= {2'b00, sel_q[1]};
        dsos_pkg::ADDR_SEL_OC:      reg_rdata <= {2'b00, sel_q[2]};
        dsos_pkg::ADDR_SEL_FAST:    reg_rdata <= {2'b00, sel_q[3]};
        dsos_pkg::ADDR_FAST_TYPE:   reg_rdata <= {7'h00, fast_type_q};
        dsos_pkg::ADDR_TERM_STATE:  reg_rdata <= {4'h0, fast_q, term_q[2:0]};
        default:                    reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_index_seen;
    encoder_index_pulse ##1 index_active;
  endsequence

  sequence s_hold_expired;
    ((index_cnt_q == 18'h0_0001) && !encoder_index_pulse) ##1 !index_active;
  endsequence

  property p_index_stretch;
    @(posedge sys_clk) disable iff (rst)
      encoder_index_pulse |-> s_index_seen;
  endproperty
  a_index_stretch: assert property (p_index_stretch)
    else $error("index pulse not stretched");

  property p_index_release;
    @(posedge sys_clk) disable iff (rst)
      ((index_cnt_q == 18'h0_0001) && !encoder_index_pulse) |-> s_hold_expired;
  endproperty
  a_index_release: assert property (p_index_release)
    else $error("index stretch did not end on time");

  property p_same_code;
    @(posedge sys_clk) disable iff (rst)
      (sel_q[0] == sel_q[1] && vt_serial_bits[0] == vt_serial_bits[1]
       && vt_fieldbus_bits[0] == vt_fieldbus_bits[1]
       && vt_ethernet_bits[0] == vt_ethernet_bits[1]
       && vt_ind_eth_bits[0] == vt_ind_eth_bits[1]) |=> relay_out_1 == relay_out_2;
  endproperty
  a_same_code: assert property (p_same_code)
    else $error("relays differ on the same code");

  property p_fault_on;
    @(posedge sys_clk) disable iff (rst)
      (sel_q[1] == dsos_pkg::FC_FAULT && drive_fault) |=> relay_out_2;
  endproperty
  a_fault_on: assert property (p_fault_on)
    else $error("fault code did not turn relay on");

  property p_zero_speed;
    @(posedge sys_clk) disable iff (rst)
      (sel_q[2] == dsos_pkg::FC_ZERO_SPEED) |=>
        oc_out == ($past(out_freq_zero) && $past(ref_freq_zero));
  endproperty
  a_zero_speed: assert property (p_zero_speed)
    else $error("zero speed output wrong");

  property p_run_reverse;
    @(posedge sys_clk) disable iff (rst)
      (sel_q[0] == dsos_pkg::FC_RUN_REV && run_reverse && !freq_output_nonzero)
        |=> !relay_out_1;
  endproperty
  a_run_reverse: assert property (p_run_reverse)
    else $error("reverse code on without output frequency");

  property p_pulse_mode;
    @(posedge sys_clk) disable iff (rst)
      (fast_type_q == dsos_pkg::FAST_TYPE_PULSE) |=> fast_pulse_out == $past(fast_pulse_train);
  endproperty
  a_pulse_mode: assert property (p_pulse_mode)
    else $error("fast terminal ignored pulse mode");

  property p_ready;
    @(posedge sys_clk) disable iff (rst)
      (sel_q[2] == dsos_pkg::FC_READY && protection_active) |=> !oc_out;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready shown while protection active");

  property p_vt_follow;
    @(posedge sys_clk) disable iff (rst)
      (sel_q[2] == dsos_pkg::FC_VT_IND_ETH) |=> oc_out == $past(vt_ind_eth_bits[2]);
  endproperty
  a_vt_follow: assert property (p_vt_follow)
    else $error("virtual bit not followed");

endmodule : dsos_selector

// ==== sim/dsos_load_model.sv ====
// External indicator wired to the terminals: counts rising edges on the open-collector output.
// Assumes terminals are synchronous to sys_clk; clr restarts the count.
`timescale 1ns/1ns

module dsos_load_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clr,
  input  wire logic       relay_out_1,
  input  wire logic       relay_out_2,
  input  wire logic       oc_out,
  input  wire logic       fast_pulse_out,
  output logic      [7:0] oc_edges_q
);
  logic oc_last_q;

  // Edge counter; relays and fast output only load the pins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      oc_last_q  <= 1'b0;
      oc_edges_q <= 8'h00;
    end else begin
      oc_last_q  <= oc_out;
      oc_edges_q <= clr ? 8'h00 : oc_edges_q + {7'h00, oc_out & ~oc_last_q};
    end
  end
endmodule : dsos_load_model

// ==== sim/dsos_selector_test.sv ====
// Self-checking bench for the terminal selector: codes, register port, pulse mode, index stretch.
// Assumes the selector drives terminals one clock after its sources and codes.
`timescale 1ns/1ns

module dsos_selector_test;
  localparam int unsigned HOLD = 20; // Short stretch keeps the run brief
  logic        sys_clk, rst, reg_wr, reg_rd, idx_pulse, ptrain, clr, prev, nb;
  logic [3:0]  reg_addr, vs, vf, ve, vi, term;
  logic [7:0]  reg_wdata, reg_rdata, oc_edges;
  logic [30:0] st;
  logic [5:0]  sel [4];
  int          bad_count, num_checks, seed, i, t;

  dsos_selector #(.INDEX_HOLD_CYCLES(HOLD)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .run_active(st[0]), .run_reverse(st[1]), .jog_active(st[2]),
    .freq_output_nonzero(st[3]), .drive_fault(st[4]), .freq_level_flag_1(st[5]),
    .freq_level_flag_2(st[6]), .freq_reached(st[7]), .out_freq_zero(st[8]),
    .ref_freq_zero(st[9]), .at_upper_limit(st[10]), .at_lower_limit(st[11]),
    .power_established(st[12]), .protection_active(st[13]), .ready_to_run(st[14]),
    .pre_exciting(st[15]), .overload_prealarm(st[16]), .underload_prealarm(st[17]),
    .simple_sequencer_stage_done(st[18]), .simple_sequencer_cycle_done(st[19]),
    .dc_bus_above_uv(st[20]), .encoder_index_pulse(idx_pulse),
    .pulse_superpose_active(st[21]), .safe_torque_off_fault(st[22]),
    .positioning_done(st[23]), .spindle_zero_done(st[24]), .spindle_div_done(st[25]),
    .torque_freq_limited(st[26]), .mode_switch_done(st[27]), .ramp_ref_above_reach(st[28]),
    .card_open_collector_out_1(st[29]), .card_open_collector_out_2(st[30]),
    .fast_pulse_train(ptrain), .vt_serial_bits(vs), .vt_fieldbus_bits(vf),
    .vt_ethernet_bits(ve), .vt_ind_eth_bits(vi), .relay_out_1(term[0]),
    .relay_out_2(term[1]), .oc_out(term[2]), .fast_pulse_out(term[3])
  );

  dsos_load_model load_u (
    .sys_clk(sys_clk), .rst(rst), .clr(clr), .relay_out_1(term[0]), .relay_out_2(term[1]),
    .oc_out(term[2]), .fast_pulse_out(term[3]), .oc_edges_q(oc_edges)
  );

  // Clock, 50 ns period
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Expected terminal level for a code, from the present source levels
  function automatic logic exp_term(input logic [5:0] c, input int tt);
    case (c)
      6'h01: return st[3] & st[0];
      6'h02: return st[3] & st[0] & ~st[1];
      6'h03: return st[3] & st[0] & st[1];
      6'h04: return st[3] & st[2];
      6'h05: return st[4];
      6'h06, 6'h07, 6'h08: return st[c - 6'h01];
      6'h09: return st[8] & st[9];
      6'h0A, 6'h0B: return st[c];
      6'h0C: return st[12] & ~st[13] & st[14];
      6'h0D: return st[15];
      6'h0E, 6'h0F: return st[c + 6'h02];
      6'h10, 6'h11: return st[c + 6'h02];
      6'h17: return vs[tt];
      6'h18: return vf[tt];
      6'h19: return ve[tt];
      6'h22: return vi[tt];
      6'h1A: return st[20];
      6'h1C: return st[21];
      6'h1D: return st[22];
      6'h1E, 6'h1F, 6'h20: return st[c - 6'h07];
      6'h24: return st[27];
      6'h21: return st[26];
      6'h25: return st[28];
      6'h29, 6'h2A: return st[c - 6'h0C];
      default: return 1'b0;
    endcase
  endfunction : exp_term

  task automatic chk_bit(input string what, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask : chk_bit

  task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk_byte

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    chk_byte("reg_rdata", e, reg_rdata);
  endtask : rd

  task automatic final_report();
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // Watchdog against a hang
  initial begin
    #(50 * 100000);
    bad_count++;
    final_report();
  end

  // Main sequence
  initial begin
    seed = 65584;
    {reg_wr, reg_rd, idx_pulse, ptrain, clr, prev} = 6'h00;
    {reg_addr, reg_wdata, st, vs, vf, ve, vi} = '0;
    rst = 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd(4'h0, 8'h01);
    rd(4'h1, 8'h05);
    rd(4'h4, 8'h00);
    wr(4'h9, 8'hFF);                                // Unmapped write ignored
    rd(4'h6, 8'h00);
    wr(4'h0, 8'hC5);
    rd(4'h0, 8'h05);
    wr(4'h4, 8'h01);
    // Pass one gives every terminal the same code, pass two random codes
    for (i = 0; i < 128; i++) begin
      for (t = 0; t < 4; t++) begin
        sel[t] = (i < 64) ? i[5:0] : 6'($random(seed));
        wr(t[3:0], {2'b00, sel[t]});
      end
      @(posedge sys_clk);
      st <= 31'($random(seed));
      {vs, vf, ve, vi} <= 16'($random(seed));
      repeat (2) @(posedge sys_clk);
      #1;
      for (t = 0; t < 4; t++) chk_bit("terminal", exp_term(sel[t], t), term[t]);
      rd(4'h5, {4'h0, exp_term(sel[3], 3), exp_term(sel[2], 2),
                exp_term(sel[1], 1), exp_term(sel[0], 0)});
    end
    // Pulse mode: fast terminal follows the train one cycle late
    wr(4'h4, 8'h00);
    @(posedge sys_clk);
    for (i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      nb = 1'($random(seed));
      ptrain <= nb;
      #1;
      if (i > 0) chk_bit("fast_pulse_out", prev, term[3]);
      prev = nb;
    end
    // Index stretch on the open-collector output, with a retrigger
    wr(4'h2, 8'h1B);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    idx_pulse <= 1'b1;
    @(posedge sys_clk);
    idx_pulse <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk_bit("oc_out", 1'b1, term[2]);
    repeat (7) @(posedge sys_clk);
    idx_pulse <= 1'b1;
    @(posedge sys_clk);
    idx_pulse <= 1'b0;
    repeat (HOLD - 3) @(posedge sys_clk);
    #1 chk_bit("oc_out", 1'b1, term[2]);
    repeat (8) @(posedge sys_clk);
    #1 chk_bit("oc_out", 1'b0, term[2]);
    chk_byte("oc_edges", 8'h01, oc_edges);
    final_report();
  end
endmodule : dsos_selector_test
